// File: inc/gld_regs.svh
// Register indices, field positions and reset values of the global register bank
`ifndef GLD_REGS_SVH
`define GLD_REGS_SVH
// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define GLD_IDX_STATUS 16'h0003
`define GLD_IDX_DET_CFG 16'hF805
`define GLD_IDX_DET_START 16'hF806
`define GLD_IDX_TEST_VALUE 16'hF807
`define GLD_IDX_TEST_STROBE 16'hF808
`define GLD_IDX_SYNC_OUT 16'hF809
`define GLD_IDX_SYNC_LOOP 16'hF80A
`define GLD_IDX_SIGNATURE 16'hF80B
`define GLD_IDX_SLOT_FIRST 16'hF820
`define GLD_IDX_SLOT_LAST 16'hF83F
`define GLD_IDX_ROUTE_CTRL 16'hF840
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define GLD_CFG_INVERT 21
`define GLD_CFG_FREE_RUN 20
`define GLD_CFG_LEAK_HI 19
`define GLD_CFG_LEAK_LO 18
`define GLD_CFG_MODE_HI 17
`define GLD_CFG_MODE_LO 16
`define GLD_CFG_IVAL_HI 15
`define GLD_CFG_WIDTH 22
`define GLD_STATUS_DONE 1
`define GLD_ROUTE_CHAN_HI 3
`define GLD_ROUTE_DET_TEST 4
`define GLD_ROUTE_INTERP 5
`define GLD_ROUTE_STROBE_BIT 11
`define GLD_ROUTE_STROBE_SEL 12
`define GLD_ROUTE_WIDTH 13
// ----------------------------------------------------------------
// Reset values and constants
// ----------------------------------------------------------------
`define GLD_RST_CFG 22'h000000
`define GLD_RST_TEST_VALUE 16'h0000
`define GLD_RST_SIGNATURE 32'h00000000
`define GLD_RST_SLOT 5'h00
`define GLD_RST_ROUTE 13'h0000
`define GLD_RESP_OKAY 2'h0
`define GLD_RESP_SLVERR 2'h2
`define GLD_LEAK_SHIFT_1 6'h08
`define GLD_LEAK_SHIFT_2 6'h0C
`define GLD_LEAK_SHIFT_3 6'h10
`endif

// File: inc/gld_pkg.sv
// Types shared by the global register bank and its level detector
package gld_pkg;
  typedef enum logic [1:0] {
    GLD_MODE_LEAKY = 2'b00,
    GLD_MODE_PEAK = 2'b01,
    GLD_MODE_INTEG = 2'b10,
    GLD_MODE_RSVD = 2'b11
  } gld_mode_e;

  typedef enum logic [2:0] {
    GLD_DT_I_HI = 3'b000,
    GLD_DT_I_LO = 3'b001,
    GLD_DT_Q_HI = 3'b010,
    GLD_DT_Q_LO = 3'b011,
    GLD_DT_MAG_HI = 3'b100,
    GLD_DT_MAG_LO = 3'b101,
    GLD_DT_PHASE = 3'b110,
    GLD_DT_AGC = 3'b111
  } gld_dtype_e;

  typedef struct packed {
    logic [1:0] channel_select_field;
    gld_dtype_e data_type_field;
  } gld_slot_s;
endpackage : gld_pkg

// File: inc/gld_det_if.sv
// Link between the register bank and the level detector
`timescale 1ns/1ps
interface gld_det_if;
  logic [21:0] cfg;
  logic [15:0] sample;
  logic sample_strobe;
  logic interp;
  logic start;
  logic [31:0] result;
  logic done_pulse;
  modport ctl (output cfg, output sample, output sample_strobe, output interp, output start,
    input result, input done_pulse);
  modport det (input cfg, input sample, input sample_strobe, input interp, input start,
    output result, output done_pulse);
endinterface : gld_det_if

// File: core/gld_level_det.sv
// Input level detector with interval counter
`timescale 1ns/1ps
`include "gld_regs.svh"
module gld_level_det (
  input wire logic aclk,
  input wire logic aresetn,
  gld_det_if.det dif
);
  import gld_pkg::*;

  logic [31:0] acc_reg;
  logic [16:0] count_reg;
  logic active_reg;
  logic done_reg;
  logic [15:0] x_fmt;
  logic [15:0] x_mag;
  logic [31:0] x_ext;
  logic [5:0] shift;
  logic signed [32:0] diff;
  logic signed [32:0] step;
  logic [32:0] sum;
  logic [31:0] acc_next;
  logic upd;
  logic last;
  gld_mode_e mode;

  assign mode = gld_mode_e'(dif.cfg[`GLD_CFG_MODE_HI:`GLD_CFG_MODE_LO]);
  // ----------------------------------------------------------------
  // Sample shaping
  // ----------------------------------------------------------------
  always_comb begin
    x_fmt = dif.cfg[`GLD_CFG_INVERT] ? ~dif.sample : dif.sample;
    if (dif.interp && dif.sample_strobe) begin
      x_fmt = 16'h0000;
    end
    x_mag = x_fmt[15] ? 16'(~x_fmt + 16'h0001) : x_fmt;
    x_ext = {x_mag, 16'h0000};
    unique case (dif.cfg[`GLD_CFG_LEAK_HI:`GLD_CFG_LEAK_LO])
      2'b00: shift = 6'h00;
      2'b01: shift = `GLD_LEAK_SHIFT_1;
      2'b10: shift = `GLD_LEAK_SHIFT_2;
      2'b11: shift = `GLD_LEAK_SHIFT_3;
    endcase
    diff = $signed({1'b0, x_ext}) - $signed({1'b0, acc_reg});
    step = diff >>> shift;
    sum = {1'b0, acc_reg} + {17'h00000, x_mag};
    unique case (mode)
      GLD_MODE_PEAK: acc_next = (x_ext > acc_reg) ? x_ext : acc_reg;
      GLD_MODE_INTEG: acc_next = sum[32] ? 32'hFFFFFFFF : sum[31:0];
      default: acc_next = 32'(acc_reg + step[31:0]);
    endcase
  end

  // Gated updates follow the strobe, interpolated ones every clock
  assign upd = (dif.interp || dif.sample_strobe) &&
    (active_reg || dif.cfg[`GLD_CFG_FREE_RUN]);
  assign last = count_reg == {1'b0, dif.cfg[`GLD_CFG_IVAL_HI:0]} + 17'h00001;

  // ----------------------------------------------------------------
  // Accumulator
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_reg <= 32'h00000000;
    end else if (dif.start) begin
      acc_reg <= 32'h00000000;
    end else if (upd) begin
      acc_reg <= acc_next;
    end
  end

  // ----------------------------------------------------------------
  // Interval counter
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_reg <= 17'h00000;
      active_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (dif.start) begin
        count_reg <= 17'h00000;
        active_reg <= 1'b1;
      end else if (active_reg && (dif.interp || dif.sample_strobe)) begin
        if (last) begin
          active_reg <= 1'b0;
          done_reg <= 1'b1;
        end else begin
          count_reg <= count_reg + 17'h00001;
        end
      end
    end
  end

  assign dif.result = acc_reg;
  assign dif.done_pulse = done_reg;
endmodule : gld_level_det

// File: core/gld_top.sv
// Global register bank: level detector control, test input, sync strobes, signature, slots
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "gld_regs.svh"
// Behaviour
// - Detector inverts the formatted sample when the invert bit is one.
// - Free-run bit ignores the interval counter; otherwise accumulation stops at expiry.
// - Leak field selects A as 1, 2^-8, 2^-12 or 2^-16.
// - Leaky mode updates Y = A*X + (1-A)*Y.
// - Mode 01 is peak detect, 10 is integrator; host keeps free-run low then.
// - Interval field holds count minus two; intervals span 2 to 65537 samples.
// - Writing the start location clears accumulator and restarts interval counter.
// - Interval expiry sets bit 1 of the status word at register 3.
// - Host test value can feed channel sections or the level detector.
// - Test strobe is channel bit 11 or the written strobe, chosen by bit 12.
// - Each test strobe write gives one sample strobe when that source is chosen.
// - Sync strobe write gives exactly one one-clock pulse on the sync output.
// - Sync out to sync in path holds at most two pipeline registers.
// - Loopback write pulses sync output and feeds the same pulse into sync in.
// - Host writes expected signature low; computed signature returns high half.
// - Each read-order slot holds channel in upper two, data type in lower three.
// - Data type codes pick I, Q, magnitude halves, phase or AGC gain.
// - Gated mode updates on strobe; interpolated updates every clock, zeroed on strobe.
// - Detector result is readable; valid once status bit 1 is set.
module gld_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [17:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [17:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [15:0] sample_in,
  input wire logic sample_strobe_in,
  output logic [15:0] test_data_out,
  output logic channel_sample_strobe,
  output logic [3:0] chan_use_test,
  output logic sync_out_pin,
  input wire logic sync_in_pin,
  output logic sync_in_int,
  output logic [15:0] bist_expected,
  input wire logic bist_done,
  input wire logic [15:0] bist_signature,
  input wire logic [4:0] slot_index,
  output logic [1:0] channel_select_field,
  output gld_pkg::gld_dtype_e data_type_field,
  input wire logic [23:0] sel_i_data,
  input wire logic [23:0] sel_q_data,
  input wire logic [23:0] sel_mag_data,
  input wire logic [15:0] sel_phase,
  input wire logic [15:0] sel_agc_gain,
  output logic [15:0] fifo_word
);
  import gld_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rdata_reg;
  logic aw_held_reg;
  logic w_held_reg;
  logic [15:0] aw_idx_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic wr_fire;
  logic [15:0] ar_idx;
  logic wr_hit;
  logic rd_hit;
  logic [31:0] rd_value;
  logic [21:0] cfg_reg;
  logic [15:0] test_value_reg;
  logic [12:0] route_reg;
  logic [31:0] signature_reg;
  gld_slot_s slots_reg [32];
  logic status_done_reg;
  logic test_strobe_reg;
  logic start_reg;
  logic sync_out_reg;
  logic sync_in_reg;
  logic chan_strobe_reg;
  gld_slot_s slot_out_reg;
  logic [15:0] fifo_word_reg;
  logic wr_start;
  logic wr_test_strobe;
  logic wr_sync;
  logic wr_loop;

  gld_det_if dif ();

  function automatic logic [31:0] gld_merge(input logic [31:0] old_v, input logic [31:0] new_v,
      input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction : gld_merge

  function automatic logic gld_mapped(input logic [15:0] idx);
    return (idx == `GLD_IDX_STATUS) || (idx == `GLD_IDX_DET_CFG) ||
      (idx == `GLD_IDX_DET_START) || (idx == `GLD_IDX_TEST_VALUE) ||
      (idx == `GLD_IDX_TEST_STROBE) || (idx == `GLD_IDX_SYNC_OUT) ||
      (idx == `GLD_IDX_SYNC_LOOP) || (idx == `GLD_IDX_SIGNATURE) ||
      (idx == `GLD_IDX_ROUTE_CTRL) ||
      ((idx >= `GLD_IDX_SLOT_FIRST) && (idx <= `GLD_IDX_SLOT_LAST));
  endfunction : gld_mapped

  // ----------------------------------------------------------------
  // Write address and data channels
  // ----------------------------------------------------------------
  assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
  assign wr_hit = gld_mapped(aw_idx_reg);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_idx_reg <= 16'h0000;
      awready_reg <= 1'b0;
    end else if (s_axi_awvalid && awready_reg) begin
      aw_held_reg <= 1'b1;
      aw_idx_reg <= s_axi_awaddr[17:2];
      awready_reg <= 1'b0;
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
    end else if (!aw_held_reg && !bvalid_reg) begin
      awready_reg <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      wready_reg <= 1'b0;
    end else if (s_axi_wvalid && wready_reg) begin
      w_held_reg <= 1'b1;
      wdata_reg <= s_axi_wdata;
      wstrb_reg <= s_axi_wstrb;
      wready_reg <= 1'b0;
    end else if (wr_fire) begin
      w_held_reg <= 1'b0;
    end else if (!w_held_reg && !bvalid_reg) begin
      wready_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Write response
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= `GLD_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_hit ? `GLD_RESP_OKAY : `GLD_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Strobe locations
  // ----------------------------------------------------------------
  assign wr_start = wr_fire && (aw_idx_reg == `GLD_IDX_DET_START);
  assign wr_test_strobe = wr_fire && (aw_idx_reg == `GLD_IDX_TEST_STROBE);
  assign wr_sync = wr_fire && (aw_idx_reg == `GLD_IDX_SYNC_OUT);
  assign wr_loop = wr_fire && (aw_idx_reg == `GLD_IDX_SYNC_LOOP);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_reg <= 1'b0;
      test_strobe_reg <= 1'b0;
    end else begin
      start_reg <= wr_start;
      test_strobe_reg <= wr_test_strobe;
    end
  end

  // ----------------------------------------------------------------
  // Sync output and internal sync input
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_out_reg <= 1'b0;
      sync_in_reg <= 1'b0;
    end else begin
      sync_out_reg <= wr_sync || wr_loop;
      sync_in_reg <= sync_in_pin || wr_loop;
    end
  end

  // ----------------------------------------------------------------
  // Configuration and data registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_reg <= `GLD_RST_CFG;
    end else if (wr_fire && (aw_idx_reg == `GLD_IDX_DET_CFG)) begin
      cfg_reg <= 22'(gld_merge({10'h000, cfg_reg}, wdata_reg, wstrb_reg));
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      test_value_reg <= `GLD_RST_TEST_VALUE;
    end else if (wr_fire && (aw_idx_reg == `GLD_IDX_TEST_VALUE)) begin
      test_value_reg <= 16'(gld_merge({16'h0000, test_value_reg}, wdata_reg, wstrb_reg));
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      route_reg <= `GLD_RST_ROUTE;
    end else if (wr_fire && (aw_idx_reg == `GLD_IDX_ROUTE_CTRL)) begin
      route_reg <= 13'(gld_merge({19'h00000, route_reg}, wdata_reg, wstrb_reg));
    end
  end

  // Host owns the low half, the self-test engine the high half
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      signature_reg <= `GLD_RST_SIGNATURE;
    end else begin
      if (wr_fire && (aw_idx_reg == `GLD_IDX_SIGNATURE)) begin
        signature_reg[15:0] <= 16'(gld_merge(signature_reg, wdata_reg, wstrb_reg));
      end
      if (bist_done) begin
        signature_reg[31:16] <= bist_signature;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int s = 0; s < 32; s++) begin
        slots_reg[s] <= `GLD_RST_SLOT;
      end
    end else if (wr_fire && (aw_idx_reg >= `GLD_IDX_SLOT_FIRST) &&
        (aw_idx_reg <= `GLD_IDX_SLOT_LAST) && wstrb_reg[0]) begin
      slots_reg[aw_idx_reg[4:0]] <= gld_slot_s'(wdata_reg[4:0]);
    end
  end

  // ----------------------------------------------------------------
  // Status word
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_done_reg <= 1'b0;
    end else if (dif.done_pulse) begin
      status_done_reg <= 1'b1;
    end else if (start_reg) begin
      status_done_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  assign ar_idx = s_axi_araddr[17:2];
  assign rd_hit = gld_mapped(ar_idx);

  always_comb begin
    rd_value = 32'h00000000;
    if (ar_idx == `GLD_IDX_STATUS) begin
      rd_value[`GLD_STATUS_DONE] = status_done_reg;
    end else if (ar_idx == `GLD_IDX_DET_CFG) begin
      rd_value = {10'h000, cfg_reg};
    end else if (ar_idx == `GLD_IDX_DET_START) begin
      rd_value = dif.result;
    end else if (ar_idx == `GLD_IDX_TEST_VALUE) begin
      rd_value = {16'h0000, test_value_reg};
    end else if (ar_idx == `GLD_IDX_SIGNATURE) begin
      rd_value = signature_reg;
    end else if (ar_idx == `GLD_IDX_ROUTE_CTRL) begin
      rd_value = {19'h00000, route_reg};
    end else if ((ar_idx >= `GLD_IDX_SLOT_FIRST) && (ar_idx <= `GLD_IDX_SLOT_LAST)) begin
      rd_value = {27'h0000000, slots_reg[ar_idx[4:0]]};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rresp_reg <= `GLD_RESP_OKAY;
      rdata_reg <= 32'h00000000;
    end else if (s_axi_arvalid && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rresp_reg <= rd_hit ? `GLD_RESP_OKAY : `GLD_RESP_SLVERR;
      rdata_reg <= rd_value;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end else if (!rvalid_reg) begin
      arready_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Test input routing
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chan_strobe_reg <= 1'b0;
    end else if (route_reg[`GLD_ROUTE_STROBE_SEL]) begin
      chan_strobe_reg <= test_strobe_reg;
    end else begin
      chan_strobe_reg <= route_reg[`GLD_ROUTE_STROBE_BIT];
    end
  end

  assign dif.cfg = cfg_reg;
  assign dif.start = start_reg;
  assign dif.interp = route_reg[`GLD_ROUTE_INTERP];
  assign dif.sample = route_reg[`GLD_ROUTE_DET_TEST] ? test_value_reg : sample_in;
  assign dif.sample_strobe = route_reg[`GLD_ROUTE_DET_TEST] ? chan_strobe_reg :
    sample_strobe_in;

  gld_level_det u_det (
    .aclk (aclk),
    .aresetn (aresetn),
    .dif (dif)
  );

  // ----------------------------------------------------------------
  // Read order slot lookup
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      slot_out_reg <= `GLD_RST_SLOT;
      fifo_word_reg <= 16'h0000;
    end else begin
      slot_out_reg <= slots_reg[slot_index];
      unique case (slot_out_reg.data_type_field)
        GLD_DT_I_HI: fifo_word_reg <= sel_i_data[23:8];
        GLD_DT_I_LO: fifo_word_reg <= {sel_i_data[7:0], 8'h00};
        GLD_DT_Q_HI: fifo_word_reg <= sel_q_data[23:8];
        GLD_DT_Q_LO: fifo_word_reg <= {sel_q_data[7:0], 8'h00};
        GLD_DT_MAG_HI: fifo_word_reg <= sel_mag_data[23:8];
        GLD_DT_MAG_LO: fifo_word_reg <= {sel_mag_data[7:0], 8'h00};
        GLD_DT_PHASE: fifo_word_reg <= sel_phase;
        GLD_DT_AGC: fifo_word_reg <= sel_agc_gain;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;
  assign test_data_out = test_value_reg;
  assign channel_sample_strobe = chan_strobe_reg;
  assign chan_use_test = route_reg[`GLD_ROUTE_CHAN_HI:0];
  assign sync_out_pin = sync_out_reg;
  assign sync_in_int = sync_in_reg;
  assign bist_expected = signature_reg[15:0];
  assign channel_select_field = slot_out_reg.channel_select_field;
  assign data_type_field = slot_out_reg.data_type_field;
  assign fifo_word = fifo_word_reg;
endmodule : gld_top

// File: tb/gld_partner.sv
// Far side model: sync loop and channel datapath values
`timescale 1ns/1ps
module gld_partner (
  input wire logic aclk,
  input wire logic sync_out_pin,
  output logic sync_in_pin,
  output logic [23:0] sel_i_data,
  output logic [23:0] sel_q_data,
  output logic [23:0] sel_mag_data,
  output logic [15:0] sel_phase,
  output logic [15:0] sel_agc_gain
);
  logic [1:0] pipe_reg = 2'h0;
  assign sync_in_pin = pipe_reg[1];
  assign sel_i_data = 24'h123456;
  assign sel_q_data = 24'h789ABC;
  assign sel_mag_data = 24'hDEF012;
  assign sel_phase = 16'h3456;
  assign sel_agc_gain = 16'h789A;
  // Two pipeline registers from sync out to sync in
  always @(posedge aclk) begin
    pipe_reg <= {pipe_reg[0], sync_out_pin};
  end
endmodule : gld_partner

// File: tb/gld_top_properties.sv
// Port-level properties of the global register bank
`timescale 1ns/1ps
module gld_top_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sync_out_pin,
  input wire logic sync_in_pin,
  input wire logic sync_in_int,
  input wire gld_pkg::gld_dtype_e data_type_field,
  input wire logic [15:0] fifo_word,
  input wire logic [23:0] sel_i_data,
  input wire logic [15:0] sel_phase
);
  import gld_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_one_pulse;
    sync_out_pin ##1 !sync_out_pin;
  endsequence
  chk_sync_one_clk: assert property ($rose(sync_out_pin) |-> s_one_pulse)
    else $error("sync pulse too wide");
  chk_sync_in_follow: assert property (sync_in_pin |=> sync_in_int)
    else $error("sync input lost");
  chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
    else $error("rdata changed");
  chk_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("awready with pending response");
  chk_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("arready with pending data");
  chk_word_phase: assert property (data_type_field == GLD_DT_PHASE |=>
    fifo_word == $past(sel_phase)) else $error("phase word wrong");
  chk_word_ilo: assert property (data_type_field == GLD_DT_I_LO |=>
    fifo_word == {$past(sel_i_data[7:0]), 8'h00}) else $error("I low word wrong");
endmodule : gld_top_properties
bind gld_top gld_top_properties u_gld_top_properties (.*);

// File: tb/gld_top_tb.sv
// Self-checking bench of the global register bank
`timescale 1ns/1ps
`include "gld_regs.svh"
module gld_top_tb;
  import gld_pkg::*;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [17:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb = 4'hF, chan_use_test;
  logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic s_axi_arvalid = '0, s_axi_rready = '0, sample_strobe_in = '0, bist_done = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic channel_sample_strobe, sync_out_pin, sync_in_pin, sync_in_int;
  logic [1:0] s_axi_bresp, s_axi_rresp, channel_select_field, rr;
  logic [15:0] sample_in = '0, bist_signature = '0, test_data_out, bist_expected, fifo_word;
  logic [15:0] sel_phase, sel_agc_gain;
  logic [23:0] sel_i_data, sel_q_data, sel_mag_data;
  logic [4:0] slot_index = '0;
  gld_dtype_e data_type_field;
  int n_fail = 0, checks_done = 0, n_so = 0, n_si = 0, n_cs = 0;
  gld_top u_gld_top (.*);
  gld_partner u_gld_partner (.*);
  initial forever #5 aclk = ~aclk;
  always @(posedge aclk) begin
    n_so <= n_so + sync_out_pin;
    n_si <= n_si + sync_in_int;
    n_cs <= n_cs + channel_sample_strobe;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task wr(input logic [15:0] i, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= {i, 2'h0};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    rr = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask : wr
  task rd(input logic [15:0] i);
    @(posedge aclk);
    s_axi_araddr <= {i, 2'h0};
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    rv = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask : rd
  task t_regs;
    wr(`GLD_IDX_DET_CFG, 32'hFFFFFFFF);
    rd(`GLD_IDX_DET_CFG);
    chk(rv, 32'h003FFFFF);
    wr(`GLD_IDX_TEST_VALUE, 32'h0001A5C3);
    chk(test_data_out, 16'hA5C3);
    wr(16'hF900, 32'h1);
    chk(rr, `GLD_RESP_SLVERR);
    rd(16'hF900);
    chk(rv, 32'h0);
    chk(rr, `GLD_RESP_SLVERR);
    wr(`GLD_IDX_SIGNATURE, 32'h55551234);
    chk(bist_expected, 16'h1234);
    bist_signature <= 16'hBEEF;
    bist_done <= 1'h1;
    @(posedge aclk);
    bist_done <= 1'h0;
    rd(`GLD_IDX_SIGNATURE);
    chk(rv, 32'hBEEF1234);
  endtask : t_regs
  task t_sync;
    int a, b;
    a = n_so;
    b = n_si;
    wr(`GLD_IDX_SYNC_OUT, 32'h0);
    repeat (8) @(posedge aclk);
    chk(n_so - a, 1);
    chk(n_si - b, 1);
    a = n_so;
    b = n_si;
    wr(`GLD_IDX_SYNC_LOOP, 32'hFFFF);
    repeat (8) @(posedge aclk);
    chk(n_so - a, 1);
    chk(n_si - b, 2);
  endtask : t_sync
  task t_strobe;
    int a;
    wr(`GLD_IDX_ROUTE_CTRL, 32'h1001);
    chk(chan_use_test, 4'h1);
    a = n_cs;
    wr(`GLD_IDX_TEST_STROBE, 32'h0);
    wr(`GLD_IDX_TEST_STROBE, 32'h0);
    repeat (4) @(posedge aclk);
    chk(n_cs - a, 2);
    wr(`GLD_IDX_ROUTE_CTRL, 32'h0800);
    @(posedge aclk);
    chk(channel_sample_strobe, 1'h1);
    wr(`GLD_IDX_ROUTE_CTRL, 32'h0);
  endtask : t_strobe
  task t_det;
    logic [15:0] smp [3];
    logic [15:0] exp [4];
    smp = '{16'hFED4, 16'h0064, 16'h0032};
    exp = '{16'h012C, 16'h012B, 16'h0064, 16'h0065};
    for (int k = 0; k < 4; k++) begin
      wr(`GLD_IDX_DET_CFG, {10'h0, k[0], 4'h0, ~k[1], 16'h0003});
      wr(`GLD_IDX_DET_START, 32'hFFFF);
      rd(`GLD_IDX_STATUS);
      chk(rv[1], 1'h0);
      for (int j = 0; j < 6; j++) begin
        sample_in <= smp[j % 3];
        sample_strobe_in <= 1'h1;
        @(posedge aclk);
        sample_strobe_in <= 1'h0;
        @(posedge aclk);
      end
      rd(`GLD_IDX_STATUS);
      chk(rv[1], 1'h1);
      rd(`GLD_IDX_DET_START);
      chk(rv, {exp[k], 16'h0});
    end
    wr(`GLD_IDX_DET_CFG, 32'h00100000);
    sample_in <= 16'h0200;
    sample_strobe_in <= 1'h1;
    wr(`GLD_IDX_DET_CFG, 32'h0);
    sample_in <= 16'h0300;
    rd(`GLD_IDX_DET_START);
    sample_strobe_in <= 1'h0;
    chk(rv, 32'h02000000);
  endtask : t_det
  task t_slot;
    logic [15:0] w [8];
    w = '{16'h1234, 16'h5600, 16'h789A, 16'hBC00, 16'hDEF0, 16'h1200, 16'h3456, 16'h789A};
    slot_index <= 5'h05;
    for (int k = 0; k < 8; k++) begin
      wr(`GLD_IDX_SLOT_FIRST + 16'h5, {27'h0, 2'h2, k[2:0]});
      rd(`GLD_IDX_SLOT_FIRST + 16'h5);
      chk(rv, {27'h0, 2'h2, k[2:0]});
      repeat (3) @(posedge aclk);
      chk(channel_select_field, 2'h2);
      chk(data_type_field, k[2:0]);
      chk(fifo_word, w[k]);
    end
  endtask : t_slot
  task final_report;
    $display("checks %0d fails %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    t_regs;
    t_sync;
    t_strobe;
    t_det;
    t_slot;
    final_report;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    final_report;
  end
endmodule : gld_top_tb
